// File: core/cycle_timer.sv
// Cycle count and cycle offset counters of the link
`timescale 1ns/1ns
module cycle_timer #(
  parameter int COUNT_W = link_ctl_pkg::CYCLE_COUNT_W,
  parameter int OFFSET_W = link_ctl_pkg::CYCLE_OFFSET_W,
  parameter logic [OFFSET_W-1:0] OFFSET_LAST =
    link_ctl_pkg::CYCLE_OFFSET_LAST
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic source_external,
  input wire logic external_rise,
  output logic [COUNT_W-1:0] cycle_count,
  output logic [OFFSET_W-1:0] cycle_offset,
  output logic count_step
);

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic [OFFSET_W-1:0] offset;
  } timer_state_s;

  timer_state_s st_reg;
  timer_state_s st_next;

  always_comb
  begin
    st_next = st_reg;
    count_step = 1'b0;
    if (source_external)
    begin
      if (external_rise)
      begin
        st_next.offset = '0;
        st_next.count = st_reg.count + 1'b1;
        count_step = 1'b1;
      end
      else if (run)
      begin
        st_next.offset = (st_reg.offset == OFFSET_LAST) ? '0 :
          st_reg.offset + 1'b1;
      end
    end
    else if (run)
    begin
      if (st_reg.offset == OFFSET_LAST)
      begin
        st_next.offset = '0;
        st_next.count = st_reg.count + 1'b1;
        count_step = 1'b1;
      end
      else
      begin
        st_next.offset = st_reg.offset + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign cycle_count = st_reg.count;
  assign cycle_offset = st_reg.offset;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_offset_hold: assert property (
    !run && !(source_external && external_rise) |=> $stable(cycle_offset))
    else $error("cycle offset moved while the timer was stopped");

  a_external_step: assert property (
    source_external && external_rise |=>
      cycle_offset == '0 && cycle_count == $past(cycle_count) + 1'b1)
    else $error("external cycle edge did not step the count");

  a_internal_rollover: assert property (
    !source_external && count_step |->
      run && cycle_offset == OFFSET_LAST)
    else $error("internal count step without offset rollover");

endmodule

// File: core/link_control_register.sv
// Link control register bank with its Avalon-MM slave and control fan-out
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
// Function
// - Writing one to bit 10 pulses a transmitter reset; bit then clears itself.
// - Writing one to bit 11 pulses a receiver reset; bit then clears itself.
// - With bit 15 set, a local bus reset loads bus number 3FFh.
// - Bits 16-17 capture the latest retry code from transmit acknowledgments.
// - Retransmitted packet retry field is ORed with the captured retry code.
// - Retry codes: 00 new, 01 retry_X, 10 retry_A, 11 retry_B.
// - Cycle master on root sends cycle-start whenever cycle count increments.
// - External source mode: each input rise steps count and clears offset.
// - Internal source mode: count steps only when the offset rolls over.
// - Cycle offset advances only while the timer run bit is set.
// - Cycle marker enable inserts a marker at each isochronous cycle end.
// - Port A enable accepts isochronous packets matching the port A channel.
// - Port B enable accepts isochronous packets matching the port B channel.
// - Ack-pending bit makes asynchronous packets get a pending acknowledgment.
// - Candidate plus auto bits set cycle master when root after bus reset.
// - Bit 29 selects dual phase retry when high, single phase when low.
// - Node number writes at 34h apply only while manual mode is set.
// - Control register resets to 0200_0000h, receiver enable only.
module link_control_register (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic external_cycle_input,
  input wire link_ctl_pkg::link_events_s events,
  output link_ctl_pkg::link_controls_s controls
);

  link_ctl_pkg::ctl_state_s st_reg;
  link_ctl_pkg::ctl_state_s st_next;

  logic [31:0] wmask;
  logic [31:0] ctl_mask;
  logic wr_accept;
  logic wr_ctl;
  logic wr_iso;
  logic wr_node;
  logic ext_rise;
  logic [link_ctl_pkg::CYCLE_COUNT_W-1:0] cycle_count;
  logic [link_ctl_pkg::CYCLE_OFFSET_W-1:0] cycle_offset;
  logic count_step;
  logic [31:0] read_mux;
  logic auto_master;
  logic [1:0] last_retry_code;

  // One wait state: every request is answered on its second edge
  assign waitrequest = (read | write) & ~st_reg.ack;
  assign wr_accept = write & st_reg.ack;
  assign wr_ctl = wr_accept && address == link_ctl_pkg::ADDR_LINK_CONTROL;
  assign wr_iso = wr_accept && address == link_ctl_pkg::ADDR_ISO_PORTS;
  assign wr_node = wr_accept && address == link_ctl_pkg::ADDR_NODE_ID;
  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                  {8{byteenable[1]}}, {8{byteenable[0]}}};
  // Reserved and hardware-owned bits never take host data
  assign ctl_mask = wmask & link_ctl_pkg::CONTROL_WRITE_MASK;
  assign ext_rise = st_reg.ext_sync & ~st_reg.ext_prev;
  assign auto_master = events.bus_reset && events.is_root &&
    st_reg.ctl[link_ctl_pkg::BIT_MASTER_CANDIDATE] &&
    st_reg.ctl[link_ctl_pkg::BIT_AUTO_MASTER];
  assign last_retry_code = st_reg.ctl[link_ctl_pkg::BIT_RETRY_HI -: 2];

  cycle_timer #(
    .COUNT_W(link_ctl_pkg::CYCLE_COUNT_W),
    .OFFSET_W(link_ctl_pkg::CYCLE_OFFSET_W),
    .OFFSET_LAST(link_ctl_pkg::CYCLE_OFFSET_LAST)
  ) u_cycle_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .run(st_reg.ctl[link_ctl_pkg::BIT_CYCLE_RUN]),
    .source_external(st_reg.ctl[link_ctl_pkg::BIT_CYCLE_SOURCE]),
    .external_rise(ext_rise),
    .cycle_count(cycle_count),
    .cycle_offset(cycle_offset),
    .count_step(count_step)
  );

  always_comb
  begin
    unique case (address)
      link_ctl_pkg::ADDR_LINK_CONTROL:
        read_mux = st_reg.ctl;
      link_ctl_pkg::ADDR_CYCLE_TIMER:
        read_mux = {7'h00, cycle_count, cycle_offset};
      link_ctl_pkg::ADDR_ISO_PORTS:
        read_mux = {18'h00000, st_reg.chan_a, 2'h0, st_reg.chan_b};
      link_ctl_pkg::ADDR_NODE_ID:
        read_mux = {16'h0000, st_reg.bus_number, st_reg.node_number};
      default:
        read_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.ack = (read | write) & ~st_reg.ack;
    st_next.ext_meta = external_cycle_input;
    st_next.ext_sync = st_reg.ext_meta;
    st_next.ext_prev = st_reg.ext_sync;
    if (read && !st_reg.ack)
      st_next.rdata = read_mux;

    // Soft resets last one cycle and clear without host action
    st_next.ctl[link_ctl_pkg::BIT_TX_SOFT_RESET] = 1'b0;
    st_next.ctl[link_ctl_pkg::BIT_RX_SOFT_RESET] = 1'b0;
    if (wr_ctl)
    begin
      st_next.ctl = (st_next.ctl & ~ctl_mask) | (writedata & ctl_mask);
      st_next.ctl[link_ctl_pkg::BIT_TX_SOFT_RESET] =
        writedata[link_ctl_pkg::BIT_TX_SOFT_RESET] &
        wmask[link_ctl_pkg::BIT_TX_SOFT_RESET];
      st_next.ctl[link_ctl_pkg::BIT_RX_SOFT_RESET] =
        writedata[link_ctl_pkg::BIT_RX_SOFT_RESET] &
        wmask[link_ctl_pkg::BIT_RX_SOFT_RESET];
    end
    if (events.ack_retry_valid)
      st_next.ctl[link_ctl_pkg::BIT_RETRY_HI -: 2] =
        events.ack_retry_code;
    if (events.bus_reset)
      st_next.ctl[link_ctl_pkg::BIT_TX_ENABLE] = 1'b0;
    if (auto_master)
      st_next.ctl[link_ctl_pkg::BIT_CYCLE_MASTER] = 1'b1;

    if (wr_iso)
    begin
      if (byteenable[1])
        st_next.chan_a = writedata[link_ctl_pkg::ISO_A_LSB +: 6];
      if (byteenable[0])
        st_next.chan_b = writedata[link_ctl_pkg::ISO_B_LSB +: 6];
    end

    if (wr_node)
    begin
      st_next.bus_number =
        (st_reg.bus_number & ~wmask[link_ctl_pkg::NODE_BUS_LSB +: 10]) |
        (writedata[link_ctl_pkg::NODE_BUS_LSB +: 10] &
         wmask[link_ctl_pkg::NODE_BUS_LSB +: 10]);
      if (st_reg.ctl[link_ctl_pkg::BIT_MANUAL_NODE_ID] && byteenable[0])
        st_next.node_number =
          writedata[link_ctl_pkg::NODE_NUMBER_LSB +: 6];
    end
    // A bus reset wins over a host write in the same cycle
    if (events.bus_reset && st_reg.ctl[link_ctl_pkg::BIT_BUS_ID_CLEAR])
      st_next.bus_number = link_ctl_pkg::BUS_NUMBER_CLEAR;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.ctl <= link_ctl_pkg::CONTROL_RESET;
      st_reg.bus_number <= link_ctl_pkg::BUS_NUMBER_CLEAR;
      st_reg.node_number <= link_ctl_pkg::NODE_NUMBER_RESET;
      st_reg.chan_a <= link_ctl_pkg::CHANNEL_RESET;
      st_reg.chan_b <= link_ctl_pkg::CHANNEL_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign readdata = st_reg.rdata;

  always_comb
  begin
    controls.tx_soft_reset =
      st_reg.ctl[link_ctl_pkg::BIT_TX_SOFT_RESET];
    controls.rx_soft_reset =
      st_reg.ctl[link_ctl_pkg::BIT_RX_SOFT_RESET];
    controls.rx_self_id_enable = st_reg.ctl[link_ctl_pkg::BIT_RX_SELF_ID];
    controls.busy_control = st_reg.ctl[link_ctl_pkg::BIT_BUSY_HI -: 3];
    controls.tx_enable = st_reg.ctl[link_ctl_pkg::BIT_TX_ENABLE];
    controls.rx_enable = st_reg.ctl[link_ctl_pkg::BIT_RX_ENABLE];
    controls.ack_pending_enable =
      st_reg.ctl[link_ctl_pkg::BIT_ACK_PENDING];
    controls.two_phase_retry_select =
      st_reg.ctl[link_ctl_pkg::BIT_TWO_PHASE_RETRY];
    controls.cycle_start_request = count_step && events.is_root &&
      st_reg.ctl[link_ctl_pkg::BIT_CYCLE_MASTER];
    controls.cycle_marker_insert = events.iso_cycle_end &&
      st_reg.ctl[link_ctl_pkg::BIT_CYCLE_MARKER];
    controls.iso_rx_accept = events.iso_header_valid &&
      ((st_reg.ctl[link_ctl_pkg::BIT_ISO_A_ENABLE] &&
        events.iso_channel == st_reg.chan_a) ||
       (st_reg.ctl[link_ctl_pkg::BIT_ISO_B_ENABLE] &&
        events.iso_channel == st_reg.chan_b));
    // Host leaves the field at new; the captured code fills it in
    controls.tx_retry_field =
      events.tx_retry_field | last_retry_code;
    controls.bus_number = st_reg.bus_number;
    controls.node_number = st_reg.node_number;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_tx_reset_write;
    wr_ctl && writedata[link_ctl_pkg::BIT_TX_SOFT_RESET] && byteenable[2];
  endsequence

  sequence s_one_cycle_pulse_tx;
    controls.tx_soft_reset ##1 !controls.tx_soft_reset;
  endsequence

  sequence s_rx_reset_write;
    wr_ctl && writedata[link_ctl_pkg::BIT_RX_SOFT_RESET] && byteenable[2];
  endsequence

  sequence s_one_cycle_pulse_rx;
    controls.rx_soft_reset ##1 !controls.rx_soft_reset;
  endsequence

  a_tx_reset_pulse: assert property (
    s_tx_reset_write |=> s_one_cycle_pulse_tx)
    else $error("transmitter soft reset not a single self-clearing pulse");

  a_rx_reset_pulse: assert property (
    s_rx_reset_write |=> s_one_cycle_pulse_rx)
    else $error("receiver soft reset not a single self-clearing pulse");

  a_bus_id_clear: assert property (
    events.bus_reset && st_reg.ctl[link_ctl_pkg::BIT_BUS_ID_CLEAR] |=>
      controls.bus_number == 10'h3ff)
    else $error("bus number not cleared on bus reset");

  a_retry_capture: assert property (
    events.ack_retry_valid |=>
      last_retry_code == $past(events.ack_retry_code))
    else $error("retry code not captured from acknowledge");

  a_retry_or: assert property (
    controls.tx_retry_field == (events.tx_retry_field | last_retry_code))
    else $error("retry field not merged with captured code");

  a_cycle_start: assert property (
    !st_reg.ctl[link_ctl_pkg::BIT_CYCLE_SOURCE] &&
      st_reg.ctl[link_ctl_pkg::BIT_CYCLE_RUN] &&
      cycle_offset == link_ctl_pkg::CYCLE_OFFSET_LAST && events.is_root &&
      st_reg.ctl[link_ctl_pkg::BIT_CYCLE_MASTER] |->
      controls.cycle_start_request)
    else $error("cycle start missing on count step as master");

  a_marker_gate: assert property (
    controls.cycle_marker_insert |->
      events.iso_cycle_end && st_reg.ctl[link_ctl_pkg::BIT_CYCLE_MARKER])
    else $error("cycle marker inserted while disabled");

  a_iso_accept: assert property (
    controls.iso_rx_accept |-> events.iso_header_valid &&
      (events.iso_channel == st_reg.chan_a ||
       events.iso_channel == st_reg.chan_b))
    else $error("isochronous packet accepted on wrong channel");

  a_auto_master: assert property (
    auto_master |=> st_reg.ctl[link_ctl_pkg::BIT_CYCLE_MASTER])
    else $error("cycle master not set automatically as root");

  a_manual_node: assert property (
    wr_node && !st_reg.ctl[link_ctl_pkg::BIT_MANUAL_NODE_ID] |=>
      $stable(controls.node_number))
    else $error("node number written outside manual mode");

  a_reserved_zero: assert property (
    (st_reg.ctl & 32'h81ce_3002) == 32'h0000_0000)
    else $error("reserved control bits not zero");

  a_answer_wait: assert property (
    (read || write) && waitrequest ##1 (read || write) |-> !waitrequest)
    else $error("bus request not answered on its second edge");

endmodule

// File: core/link_ctl_pkg.sv
// Constants, field layouts and carrier types for the link control register
package link_ctl_pkg;

  // Byte addresses on the register bus
  localparam logic [7:0] ADDR_LINK_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_CYCLE_TIMER = 8'h18;
  localparam logic [7:0] ADDR_ISO_PORTS = 8'h1c;
  localparam logic [7:0] ADDR_NODE_ID = 8'h34;

  // Control word: bit 0 of the field table is vector bit 31
  localparam logic [31:0] CONTROL_RESET = 32'h0200_0000;
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'h7e01_0ffd;
  localparam int BIT_RX_SELF_ID = 30;
  localparam int BIT_BUSY_HI = 29;
  localparam int BIT_TX_ENABLE = 26;
  localparam int BIT_RX_ENABLE = 25;
  localparam int BIT_TX_SOFT_RESET = 21;
  localparam int BIT_RX_SOFT_RESET = 20;
  localparam int BIT_BUS_ID_CLEAR = 16;
  localparam int BIT_RETRY_HI = 15;
  localparam int BIT_CYCLE_MASTER = 11;
  localparam int BIT_CYCLE_SOURCE = 10;
  localparam int BIT_CYCLE_RUN = 9;
  localparam int BIT_CYCLE_MARKER = 8;
  localparam int BIT_ISO_A_ENABLE = 7;
  localparam int BIT_ISO_B_ENABLE = 6;
  localparam int BIT_ACK_PENDING = 5;
  localparam int BIT_MASTER_CANDIDATE = 4;
  localparam int BIT_AUTO_MASTER = 3;
  localparam int BIT_TWO_PHASE_RETRY = 2;
  localparam int BIT_MANUAL_NODE_ID = 0;

  // Field positions in the other registers
  localparam int CYCLE_COUNT_LSB = 12;
  localparam int ISO_A_LSB = 8;
  localparam int ISO_B_LSB = 0;
  localparam int NODE_BUS_LSB = 6;
  localparam int NODE_NUMBER_LSB = 0;

  // Widths and reset values
  localparam int CYCLE_COUNT_W = 13;
  localparam int CYCLE_OFFSET_W = 12;
  localparam logic [11:0] CYCLE_OFFSET_LAST = 12'hbff;
  localparam logic [9:0] BUS_NUMBER_CLEAR = 10'h3ff;
  localparam logic [5:0] NODE_NUMBER_RESET = 6'h3f;
  localparam logic [5:0] CHANNEL_RESET = 6'h00;

  typedef enum logic [1:0] {
    RETRY_NEW = 2'h0,
    RETRY_X = 2'h1,
    RETRY_A = 2'h2,
    RETRY_B = 2'h3
  } retry_code_e;

  // Events and data arriving from the link core
  typedef struct packed {
    logic bus_reset;
    logic is_root;
    logic ack_retry_valid;
    retry_code_e ack_retry_code;
    logic iso_cycle_end;
    logic iso_header_valid;
    logic [5:0] iso_channel;
    logic [1:0] tx_retry_field;
  } link_events_s;

  // Controls driven back into the link core
  typedef struct packed {
    logic tx_soft_reset;
    logic rx_soft_reset;
    logic rx_self_id_enable;
    logic [2:0] busy_control;
    logic tx_enable;
    logic rx_enable;
    logic ack_pending_enable;
    logic two_phase_retry_select;
    logic cycle_start_request;
    logic cycle_marker_insert;
    logic iso_rx_accept;
    logic [1:0] tx_retry_field;
    logic [9:0] bus_number;
    logic [5:0] node_number;
  } link_controls_s;

  typedef struct packed {
    logic ack;
    logic [31:0] ctl;
    logic [9:0] bus_number;
    logic [5:0] node_number;
    logic [5:0] chan_a;
    logic [5:0] chan_b;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic [31:0] rdata;
  } ctl_state_s;

endpackage

// File: tb/link_control_register_tb.sv
// Register-level tests of the link control register bank
`timescale 1ns/1ns
module link_control_register_tb;
  logic core_clk;
  logic rst_b;
  logic read;
  logic write;
  logic [7:0] address;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic [31:0] t0;
  logic [3:0] byteenable;
  logic waitrequest;
  logic external_cycle_input;
  link_ctl_pkg::link_events_s events;
  link_ctl_pkg::link_events_s ev;
  link_ctl_pkg::link_controls_s controls;
  int err_count;
  int cmp_count;
  int starts;
  int starts0;

  link_control_register i_link_control_register (
    .core_clk(core_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .external_cycle_input(external_cycle_input), .events(events),
    .controls(controls)
  );

  link_core_model i_link_core_model (
    .core_clk(core_clk), .rst_b(rst_b), .events(events),
    .external_cycle_input(external_cycle_input)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (controls.cycle_start_request === 1'b1)
      starts <= starts + 1;

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  task automatic bus_read(input logic [7:0] a);
    @(posedge core_clk);
    address <= a;
    read <= 1'b1;
    do @(posedge core_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
  endtask

  task automatic bus_reset_pulse();
    ev.bus_reset = 1'b1;
    i_link_core_model.raise(ev);
    ev.bus_reset = 1'b0;
    i_link_core_model.drop();
  endtask

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    err_count = 0;
    cmp_count = 0;
    ev = '0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    bus_read(8'h08);
    check("reset control", rd, 32'h0200_0000);
    check("rx enable", 32'(controls.rx_enable), 32'h1);
    bus_read(8'h34);
    check("reset node id", rd, 32'h0000_ffff);
    bus_write(8'h08, 32'hffff_ffff);
    bus_read(8'h08);
    check("control all ones", rd, 32'h7e01_0ffd);
    t0 = 32'({controls.rx_self_id_enable, controls.busy_control,
      controls.tx_enable});
    check("plain fields", t0, 32'h0000_001f);
    check("ack pending on", 32'(controls.ack_pending_enable), 1);
    check("dual retry on", 32'(controls.two_phase_retry_select), 1);
    bus_write(8'h08, 32'h0);
    bus_read(8'h08);
    check("control cleared", rd, 32'h0);
    check("ack pending off", 32'(controls.ack_pending_enable), 0);
    check("dual retry off", 32'(controls.two_phase_retry_select), 0);
    // Soft reset pulses last one cycle and the bit reads back clear
    for (int i = 0; i < 2; i++)
    begin
      bus_write(8'h08, i ? 32'h0010_0000 : 32'h0020_0000);
      #1;
      t0 = 32'({controls.rx_soft_reset, controls.tx_soft_reset});
      check("soft reset pulse", t0, i ? 2 : 1);
      @(posedge core_clk);
      #1;
      t0 = 32'({controls.rx_soft_reset, controls.tx_soft_reset});
      check("soft reset end", t0, 0);
      bus_read(8'h08);
      check("soft reset bit", rd, 0);
    end
    check("retry codes", 32'({link_ctl_pkg::RETRY_X, link_ctl_pkg::RETRY_A,
      link_ctl_pkg::RETRY_B}), 32'h1b);
    for (int c = 0; c < 4; c++)
    begin
      ev.ack_retry_valid = 1'b1;
      ev.ack_retry_code = link_ctl_pkg::retry_code_e'(c[1:0]);
      ev.tx_retry_field = c[1:0] ^ 2'h1;
      i_link_core_model.raise(ev);
      ev.ack_retry_valid = 1'b0;
      i_link_core_model.drop();
      #1;
      check("resend retry", 32'(controls.tx_retry_field), c | 1);
      bus_read(8'h08);
      check("captured retry", rd, c << 14);
    end
    // Node number is locked until manual mode is set
    bus_write(8'h34, 32'h0000_0141);
    bus_read(8'h34);
    check("node locked", rd, 32'h0000_017f);
    bus_write(8'h08, 32'h0000_0001);
    bus_write(8'h34, 32'h0000_0141);
    bus_read(8'h34);
    check("node manual", rd, 32'h0000_0141);
    bus_reset_pulse();
    bus_read(8'h34);
    check("bus id kept", rd, 32'h0000_0141);
    ev.is_root = 1'b1;
    bus_write(8'h08, 32'h0001_0010);
    bus_reset_pulse();
    bus_read(8'h34);
    check("bus id cleared", rd, 32'h0000_ffc1);
    t0 = 32'({controls.bus_number, controls.node_number});
    check("node out", t0, 32'h0000_ffc1);
    // The last captured retry code (11) stays in bits 15:14
    bus_read(8'h08);
    check("no auto master", rd, 32'h0001_c010);
    bus_write(8'h08, 32'h0000_0018);
    bus_reset_pulse();
    bus_read(8'h08);
    check("auto master", rd, 32'h0000_c818);
    // Timer holds while stopped, then rolls once per 3072 cycles
    bus_read(8'h18);
    t0 = rd;
    repeat (50) @(posedge core_clk);
    bus_read(8'h18);
    check("timer stopped", rd, t0);
    bus_write(8'h08, 32'h0000_0a00);
    bus_read(8'h18);
    t0 = rd;
    starts0 = starts;
    repeat (3069) @(posedge core_clk);
    bus_read(8'h18);
    check("timer rollover", rd, t0 + 32'h1000);
    check("cycle starts", starts - starts0, 1);
    bus_write(8'h08, 32'h0000_0000);
    bus_read(8'h18);
    t0 = rd;
    i_link_core_model.cycle_rises(2);
    bus_read(8'h18);
    check("pin ignored", rd, t0);
    bus_write(8'h08, 32'h0000_0600);
    bus_read(8'h18);
    t0 = rd;
    i_link_core_model.cycle_rises(3);
    bus_read(8'h18);
    check("ext count", 32'(rd[24:12]), 32'(t0[24:12]) + 3);
    check("ext offset", 32'(rd[11:0] < 12'h020), 1);
    // Port A and B channel matching, marker with port A only
    bus_write(8'h1c, 32'h0000_0509);
    bus_read(8'h1c);
    check("iso ports", rd, 32'h0000_0509);
    for (int m = 0; m < 4; m++)
    begin
      bus_write(8'h08, m[1] ? 32'h0000_0040 : 32'h0000_0180);
      ev.iso_header_valid = 1'b1;
      ev.iso_cycle_end = 1'b1;
      ev.iso_channel = m[0] ? 6'h09 : 6'h05;
      i_link_core_model.raise(ev);
      #1;
      t0 = 32'(controls.iso_rx_accept);
      check("iso accept", t0, m == 0 || m == 3);
      check("marker", 32'(controls.cycle_marker_insert), !m[1]);
      ev.iso_header_valid = 1'b0;
      ev.iso_cycle_end = 1'b0;
      i_link_core_model.drop();
    end
    bus_write(8'h3c, 32'hffff_ffff);
    bus_read(8'h3c);
    check("unmapped", rd, 32'h0);
    finish_test();
  end
endmodule

// File: tb/link_core_model.sv
// Link core side model: event pulses, root level and the cycle pin
`timescale 1ns/1ns
module link_core_model (
  input wire logic core_clk,
  input wire logic rst_b,
  output link_ctl_pkg::link_events_s events,
  output logic external_cycle_input
);
  initial
  begin
    events = '0;
    external_cycle_input = 1'b0;
  end

  // Drives a full event word; levels stay until the next raise
  task automatic raise(input link_ctl_pkg::link_events_s ev);
    @(posedge core_clk);
    events <= ev;
  endtask

  // Ends every pulse after exactly one cycle
  task automatic drop();
    @(posedge core_clk);
    events.bus_reset <= 1'b0;
    events.ack_retry_valid <= 1'b0;
    events.iso_cycle_end <= 1'b0;
    events.iso_header_valid <= 1'b0;
  endtask

  // Rising edges on the cycle pin, spaced past the synchroniser
  task automatic cycle_rises(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      external_cycle_input <= 1'b1;
      repeat (4) @(posedge core_clk);
      external_cycle_input <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule
